// ---- common/plc_defs.svh ----
// Offsets, field positions, reset values and timing counts of the low-speed control block
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

`define PLC_CLK_MHZ        200
`define PLC_RESET_MIN_NS   10000
`define PLC_RESET_MIN_CYC  ((`PLC_RESET_MIN_NS * `PLC_CLK_MHZ + 999) / 1000)
`define PLC_INIT_NS        100
`define PLC_INIT_CYC       ((`PLC_INIT_NS * `PLC_CLK_MHZ + 999) / 1000)

`define PLC_LANES          4
`define PLC_DEV_ADDR       7'h50

`define PLC_A_STATUS       8'h00
`define PLC_A_INT          8'h01
`define PLC_A_LOS          8'h02
`define PLC_A_TXDIS        8'h03
`define PLC_A_PWR          8'h04
`define PLC_A_THR          8'h05
`define PLC_A_LANE0        8'h06

`define PLC_F_DNR          0
`define PLC_F_RDONE        0
`define PLC_F_LOSL         4
`define PLC_F_PWR_OVR      0
`define PLC_F_PWR_SET      1

`define PLC_TXDIS_RST      4'h0
`define PLC_PWR_RST        2'h0
`define PLC_THR_RST        8'h20

`endif

// ---- common/plc_pkg.sv ----
// Types shared by the low-speed control block
package plc_pkg;
    typedef logic [7:0] plc_byte_type;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_INIT  = 2'b01,
        ST_READY = 2'b11
    } plc_ctrl_state_type;

    typedef enum logic [3:0] {
        SL_IDLE    = 4'h0,
        SL_DEV     = 4'h1,
        SL_DEV_ACK = 4'h3,
        SL_REG     = 4'h2,
        SL_REG_ACK = 4'h6,
        SL_WR      = 4'h7,
        SL_WR_ACK  = 4'h5,
        SL_RD      = 4'h4,
        SL_RD_ACK  = 4'hc
    } plc_slave_state_type;
endpackage

// ---- common/plc_if.sv ----
// Memory-map access path between the serial slave and the control core
`timescale 1ns/1ps
interface plc_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic [7:0] rdata;
    logic       sel;
    modport slave (output addr, output wdata, output wr, input rdata, input sel);
    modport regs  (input addr, input wdata, input wr, output rdata, output sel);
endinterface

// ---- core/plc_i2c_slave.sv ----
// Two-wire serial slave giving access to the management memory map
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_i2c_slave import plc_pkg::*; (
    input  wire logic clock_i,   // System clock
    input  wire logic rst_i,     // Synchronous reset
    input  wire logic scl_i,     // Serial clock pin
    input  wire logic sda_i,     // Serial data pin, sensed
    output logic      sda_o,     // Serial data drive level
    output logic      sda_oe_o,  // Serial data pulled low when high
    plc_if.slave      bus        // Memory-map access
);
    logic                [1:0] scl_m_r;
    logic                [1:0] sda_m_r;
    logic                      scl_d_r;
    logic                      sda_d_r;
    plc_slave_state_type       state_r;
    logic                [3:0] bitcnt_r;
    logic                [7:0] shift_r;
    logic                [7:0] ptr_r;
    logic                [7:0] wdata_r;
    logic                      wr_r;
    logic                      rw_r;
    logic                      oe_r;

    wire scl_s     = scl_m_r[1];
    wire sda_s     = sda_m_r[1];
    wire scl_rise  = scl_s & ~scl_d_r;
    wire scl_fall  = ~scl_s & scl_d_r;
    wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire byte_done = (bitcnt_r == 4'h8);

    always_ff @(posedge clock_i) begin
        scl_m_r <= {scl_m_r[0], scl_i};
        sda_m_r <= {sda_m_r[0], sda_i};
        scl_d_r <= scl_s;
        sda_d_r <= sda_s;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r  <= SL_IDLE;
            bitcnt_r <= 4'h0;
            shift_r  <= 8'h00;
            ptr_r    <= 8'h00;
            wdata_r  <= 8'h00;
            wr_r     <= 1'b0;
            rw_r     <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            wr_r <= 1'b0;
            if (!bus.sel || bus_stop) begin
                state_r <= SL_IDLE;
                oe_r    <= 1'b0;
            end else if (bus_start) begin
                state_r  <= SL_DEV;
                bitcnt_r <= 4'h0;
                oe_r     <= 1'b0;
            end else if (scl_rise) begin
                case (state_r)
                    SL_DEV, SL_REG, SL_WR: begin
                        shift_r  <= {shift_r[6:0], sda_s};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                    SL_RD:     bitcnt_r <= bitcnt_r + 4'h1;
                    SL_RD_ACK: if (sda_s) state_r <= SL_IDLE;
                    default:   ;
                endcase
            end else if (scl_fall) begin
                case (state_r)
                    SL_DEV: if (byte_done) begin
                        if (shift_r[7:1] == `PLC_DEV_ADDR) begin
                            oe_r    <= 1'b1;
                            rw_r    <= shift_r[0];
                            state_r <= SL_DEV_ACK;
                        end else begin
                            state_r <= SL_IDLE;
                        end
                    end
                    SL_REG: if (byte_done) begin
                        ptr_r   <= shift_r;
                        oe_r    <= 1'b1;
                        state_r <= SL_REG_ACK;
                    end
                    SL_WR: if (byte_done) begin
                        wdata_r <= shift_r;
                        wr_r    <= 1'b1;
                        oe_r    <= 1'b1;
                        state_r <= SL_WR_ACK;
                    end
                    SL_REG_ACK, SL_WR_ACK: begin
                        if (state_r == SL_WR_ACK) ptr_r <= ptr_r + 8'h01;
                        oe_r     <= 1'b0;
                        bitcnt_r <= 4'h0;
                        state_r  <= SL_WR;
                    end
                    SL_DEV_ACK, SL_RD_ACK: begin
                        bitcnt_r <= 4'h0;
                        if (state_r == SL_DEV_ACK && !rw_r) begin
                            oe_r    <= 1'b0;
                            state_r <= SL_REG;
                        end else begin
                            shift_r <= bus.rdata;
                            oe_r    <= ~bus.rdata[7];
                            ptr_r   <= ptr_r + 8'h01;
                            state_r <= SL_RD;
                        end
                    end
                    SL_RD: begin
                        // Release before the master's acknowledge slot
                        if (byte_done) begin
                            oe_r    <= 1'b0;
                            state_r <= SL_RD_ACK;
                        end else begin
                            oe_r <= ~shift_r[~bitcnt_r[2:0]];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    assign sda_o     = 1'b0;
    assign sda_oe_o  = oe_r;
    assign bus.addr  = ptr_r;
    assign bus.wdata = wdata_r;
    assign bus.wr    = wr_r;

    property p_ignore_bus;
        @(posedge clock_i) disable iff (rst_i)
        !bus.sel |=> (state_r == SL_IDLE) && !sda_oe_o;
    endproperty
    a_ignore_bus: assert property (p_ignore_bus) else $error("bus answered while deselected");

    property p_write_path;
        @(posedge clock_i) disable iff (rst_i)
        bus.wr |-> (state_r == SL_WR_ACK) && $past(state_r) == SL_WR && sda_oe_o;
    endproperty
    a_write_path: assert property (p_write_path) else $error("write strobe out of data phase");
endmodule

// ---- core/plc_ctrl.sv ----
// Low-speed management and control core of a four-lane pluggable module
// Function
// - Nine low-speed pins including both serial lines
// - Serial bus answered only while select low
// - Serial lines read and write memory map
// - Long reset pulse restores all default settings
// - Completion: interrupt asserted, data-not-ready cleared together
// - Power-up raises completion interrupt unprompted
// - Transmitter off by pin or serial command
// - Every lane's received power readable serially
// - Loss alarm when any lane below threshold
// - Low-power input caps maximum power draw while the power override bit is clear
// - Presence line pulled low while inserted
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_ctrl import plc_pkg::*; (
    input  wire logic        clock_i,               // 200 MHz system clock
    input  wire logic        rst_i,                 // Power-on reset, synchronous
    input  wire logic        module_select_n_i,     // Select pin, low enables bus
    input  wire logic        module_reset_n_i,      // Reset pin, active low
    input  wire logic        low_power_request_i,   // Low-power mode pin
    input  wire logic        transmit_disable_i,    // Hardware transmit-disable pin
    input  wire logic        scl_i,                 // Serial clock pin
    input  wire logic        sda_i,                 // Serial data pin, sensed
    output logic             sda_o,                 // Serial data drive level
    output logic             sda_oe_o,              // Serial data drive enable
    input  wire logic [31:0] rx_power_i,            // Lane power monitor, 8 bits a lane
    output logic             presence_detect_n_o,   // Presence drive level
    output logic             presence_detect_oe_o,  // Presence drive enable
    output logic             host_interrupt_n_o,    // Interrupt drive level
    output logic             host_interrupt_oe_o,   // Interrupt drive enable
    output logic             receive_signal_loss_o, // Loss-of-signal alarm
    output logic [3:0]       tx_off_o,              // Per-lane transmitter off
    output logic             power_limit_o,         // Maximum power limited
    output logic             data_not_ready_o       // Status flag copy
);
    localparam int RST_CYC  = `PLC_RESET_MIN_CYC;
    localparam int INIT_CYC = `PLC_INIT_CYC;

    plc_if bus ();

    // Pins from outside the clock domain
    logic [1:0]         sel_m_r;
    logic [1:0]         rstn_m_r;
    logic [1:0]         lpm_m_r;
    logic [1:0]         txd_m_r;

    logic [11:0]        rst_cnt_r;
    logic [11:0]        rst_cnt_nxt;
    logic [7:0]         init_cnt_r;
    plc_ctrl_state_type state_r;
    plc_ctrl_state_type state_nxt;

    logic               dnr_r;
    logic               rdone_r;
    logic [3:0]         los_latch_r;
    logic [3:0]         txdis_r;
    logic [1:0]         pwr_r;
    logic [7:0]         thr_r;
    plc_byte_type       lane_r [`PLC_LANES];
    logic [3:0]         los_r;
    logic [3:0]         tx_off_r;
    logic               pwr_lim_r;

    function automatic plc_byte_type lane_power(input logic [31:0] v, input logic [1:0] i);
        lane_power = v[{i, 3'b000} +: 8];
    endfunction

    always_ff @(posedge clock_i) begin
        sel_m_r  <= {sel_m_r[0], module_select_n_i};
        rstn_m_r <= {rstn_m_r[0], module_reset_n_i};
        lpm_m_r  <= {lpm_m_r[0], low_power_request_i};
        txd_m_r  <= {txd_m_r[0], transmit_disable_i};
    end

    wire sel_n_s = sel_m_r[1];
    wire rstn_s  = rstn_m_r[1];
    wire lpm_s   = lpm_m_r[1];
    wire txd_s   = txd_m_r[1];

    // Short glitches on the reset pin are filtered by the count
    wire rst_long = (rst_cnt_r == 12'(RST_CYC));
    assign rst_cnt_nxt = rstn_s ? 12'h000 : (rst_long ? rst_cnt_r : rst_cnt_r + 12'h001);
    wire soft_rst = rst_long & ~rstn_s;

    always_ff @(posedge clock_i) begin
        if (rst_i) rst_cnt_r <= 12'h000;
        else rst_cnt_r <= rst_cnt_nxt;
    end

    // Reset sequencing
    wire init_done = (init_cnt_r == 8'(INIT_CYC));
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: if (!soft_rst) state_nxt = ST_INIT;
            ST_INIT:  if (soft_rst) state_nxt = ST_RESET;
                      else if (init_done) state_nxt = ST_READY;
            ST_READY: if (soft_rst) state_nxt = ST_RESET;
            default:  state_nxt = ST_RESET;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r    <= ST_RESET;
            init_cnt_r <= 8'h00;
        end else begin
            state_r    <= state_nxt;
            init_cnt_r <= (state_r == ST_INIT && !init_done) ? init_cnt_r + 8'h01 : 8'h00;
        end
    end

    wire done_evt = (state_r == ST_INIT) && (state_nxt == ST_READY);
    wire in_reset = rst_i | soft_rst;

    // Register writes from the serial slave
    wire wr_int   = bus.wr && bus.addr == `PLC_A_INT;
    wire wr_txdis = bus.wr && bus.addr == `PLC_A_TXDIS;
    wire wr_pwr   = bus.wr && bus.addr == `PLC_A_PWR;
    wire wr_thr   = bus.wr && bus.addr == `PLC_A_THR;
    wire [3:0] los_now;

    always_ff @(posedge clock_i) begin
        if (in_reset) begin
            dnr_r   <= 1'b1;
            txdis_r <= `PLC_TXDIS_RST;
            pwr_r   <= `PLC_PWR_RST;
            thr_r   <= `PLC_THR_RST;
        end else begin
            if (done_evt) dnr_r <= 1'b0;
            if (wr_txdis) txdis_r <= bus.wdata[3:0];
            if (wr_pwr) pwr_r <= bus.wdata[1:0];
            if (wr_thr) thr_r <= bus.wdata;
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (in_reset) begin
            rdone_r     <= 1'b0;
            los_latch_r <= 4'h0;
        end else begin
            rdone_r <= done_evt | (rdone_r & ~(wr_int & bus.wdata[`PLC_F_RDONE]));
            los_latch_r <= los_now | (los_latch_r & ~({4{wr_int}} & bus.wdata[7:4]));
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PLC_LANES; g++) begin : g_lane
            assign los_now[g] = lane_power(rx_power_i, 2'(g)) < thr_r;
            always_ff @(posedge clock_i) begin
                if (rst_i) lane_r[g] <= 8'h00;
                else lane_r[g] <= lane_power(rx_power_i, 2'(g));
            end
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            los_r     <= 4'h0;
            tx_off_r  <= 4'hf;
            pwr_lim_r <= 1'b1;
        end else begin
            los_r     <= los_now;
            tx_off_r  <= {4{txd_s}} | txdis_r;
            pwr_lim_r <= pwr_r[`PLC_F_PWR_OVR] ? pwr_r[`PLC_F_PWR_SET] : lpm_s;
        end
    end

    // Read multiplexer; unmapped offsets read zero
    wire [7:0] lane_off = bus.addr - `PLC_A_LANE0;
    wire       lane_hit = bus.addr >= `PLC_A_LANE0 && lane_off < 8'(`PLC_LANES);
    wire [7:0] rd_mux =
        (bus.addr == `PLC_A_STATUS) ? {7'h00, dnr_r} :
        (bus.addr == `PLC_A_INT)    ? {los_latch_r, 3'h0, rdone_r} :
        (bus.addr == `PLC_A_LOS)    ? {4'h0, los_r} :
        (bus.addr == `PLC_A_TXDIS)  ? {4'h0, txdis_r} :
        (bus.addr == `PLC_A_PWR)    ? {6'h00, pwr_r} :
        (bus.addr == `PLC_A_THR)    ? thr_r :
        lane_hit                    ? lane_r[lane_off[1:0]] : 8'h00;
    assign bus.rdata = rd_mux;

    assign bus.sel = ~sel_n_s;

    plc_i2c_slave u_slave (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .sda_o   (sda_o),
        .sda_oe_o(sda_oe_o),
        .bus     (bus)
    );

    // Pending while the completion or any loss event is unacknowledged
    wire int_pend = rdone_r | (|los_latch_r);
    assign host_interrupt_n_o    = 1'b0;
    assign host_interrupt_oe_o   = int_pend;
    assign presence_detect_n_o   = 1'b0;
    assign presence_detect_oe_o  = 1'b1;
    assign receive_signal_loss_o = |los_r;
    assign tx_off_o              = tx_off_r;
    assign power_limit_o         = pwr_lim_r;
    assign data_not_ready_o      = dnr_r;

    property p_reset_defaults;
        @(posedge clock_i) disable iff (rst_i)
        soft_rst |=> dnr_r && txdis_r == `PLC_TXDIS_RST && thr_r == `PLC_THR_RST && !rdone_r;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("settings not defaulted");

    property p_completion;
        @(posedge clock_i) disable iff (rst_i)
        $fell(dnr_r) |-> rdone_r && host_interrupt_oe_o && !host_interrupt_n_o;
    endproperty
    a_completion: assert property (p_completion) else $error("completion not signalled");

    property p_powerup;
        @(posedge clock_i)
        rst_i ##1 !rst_i [*2] ##0 rstn_s |-> ##[1:60] !dnr_r;
    endproperty
    a_powerup: assert property (p_powerup) else $error("no completion after power-up");

    property p_txoff;
        @(posedge clock_i) disable iff (rst_i)
        txd_s |=> tx_off_o == 4'hf;
    endproperty
    a_txoff: assert property (p_txoff) else $error("transmitter on while disabled");

    property p_lane_read;
        @(posedge clock_i) disable iff (rst_i)
        bus.addr == `PLC_A_LANE0 |-> bus.rdata == lane_r[0];
    endproperty
    a_lane_read: assert property (p_lane_read) else $error("lane power readback wrong");

    property p_los;
        @(posedge clock_i) disable iff (rst_i)
        (|los_now) |=> receive_signal_loss_o;
    endproperty
    a_los: assert property (p_los) else $error("loss alarm missing");

    property p_lpm;
        @(posedge clock_i) disable iff (rst_i)
        !pwr_r[`PLC_F_PWR_OVR] && $stable(pwr_r) |=> power_limit_o == $past(lpm_s);
    endproperty
    a_lpm: assert property (p_lpm) else $error("power limit ignores low-power pin");

    property p_presence;
        @(posedge clock_i)
        presence_detect_oe_o && !presence_detect_n_o;
    endproperty
    a_presence: assert property (p_presence) else $error("presence not pulled low");

    property p_int_release;
        @(posedge clock_i) disable iff (rst_i)
        !rdone_r && los_latch_r == 4'h0 |-> !host_interrupt_oe_o;
    endproperty
    a_int_release: assert property (p_int_release) else $error("interrupt held with none pending");
endmodule

// ---- verification/plc_host_model.sv ----
// Host controller model: drives the two-wire link of the module
`timescale 1ns/1ps
module plc_host_model (
    input  wire logic clock_i,   // System clock, paces the link
    input  wire logic sda_i,     // Resolved serial data level
    output logic      scl_o,     // Serial clock drive level
    output logic      sda_low_o  // High pulls serial data low
);
    // Clock stands high between frames, data released to the pull-up
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // 16 cycles a bit gives the 80 ns link period
    task automatic send_bit(input logic b, output logic seen);
        scl_o = 1'b0;
        wait_clk(4);
        sda_low_o = ~b;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(4);
        seen = sda_i;
        wait_clk(4);
    endtask

    // Also serves as repeated start after an acknowledge bit
    task automatic start_cond();
        scl_o = 1'b0;
        wait_clk(4);
        sda_low_o = 1'b0;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(8);
        sda_low_o = 1'b1;
        wait_clk(8);
    endtask

    task automatic stop_cond();
        scl_o = 1'b0;
        wait_clk(4);
        sda_low_o = 1'b1;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(8);
        sda_low_o = 1'b0;
        wait_clk(8);
    endtask

    // Ninth bit: 1 releases for the module's ack, 0 is the host's ack
    task automatic xfer(input logic [7:0] tx, input logic last,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(tx[i], s);
            rx[i] = s;
        end
        send_bit(last, s);
        ack = ~s;
    endtask
endmodule

// ---- verification/plc_ctrl_bench.sv ----
// Self-checking bench of the low-speed control block
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_ctrl_bench;
    logic        clock_i;
    logic        rst_i;
    logic        sel_n;
    logic        rst_n;
    logic        lpm;
    logic        txdis;
    logic [31:0] rx_power;
    logic        scl;
    logic        host_low;
    logic        sda_o;
    logic        sda_oe;
    logic        prs_n;
    logic        prs_oe;
    logic        int_n;
    logic        int_oe;
    logic        loss;
    logic [3:0]  tx_off;
    logic        pwr_lim;
    logic        dnr;
    wire         sda_line;
    int          mismatches;
    int          check_count;

    // Open-drain wire with pull-up
    assign sda_line = ~(host_low | (sda_oe & ~sda_o));

    plc_ctrl DUT (
        .clock_i               (clock_i),
        .rst_i                 (rst_i),
        .module_select_n_i     (sel_n),
        .module_reset_n_i      (rst_n),
        .low_power_request_i   (lpm),
        .transmit_disable_i    (txdis),
        .scl_i                 (scl),
        .sda_i                 (sda_line),
        .sda_o                 (sda_o),
        .sda_oe_o              (sda_oe),
        .rx_power_i            (rx_power),
        .presence_detect_n_o   (prs_n),
        .presence_detect_oe_o  (prs_oe),
        .host_interrupt_n_o    (int_n),
        .host_interrupt_oe_o   (int_oe),
        .receive_signal_loss_o (loss),
        .tx_off_o              (tx_off),
        .power_limit_o         (pwr_lim),
        .data_not_ready_o      (dnr)
    );

    plc_host_model host (
        .clock_i   (clock_i),
        .sda_i     (sda_line),
        .scl_o     (scl),
        .sda_low_o (host_low)
    );

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Pins pass two sync stages and one register
    task automatic settle();
        repeat (6) @(negedge clock_i);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, input logic ackx);
        logic [7:0] r;
        logic       k;
        host.start_cond();
        host.xfer({`PLC_DEV_ADDR, 1'b0}, 1'b1, r, k);
        check("address ack", {7'h0, k}, {7'h0, ackx});
        host.xfer(a, 1'b1, r, k);
        host.xfer(d, 1'b1, r, k);
        host.stop_cond();
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        logic       k;
        host.start_cond();
        host.xfer({`PLC_DEV_ADDR, 1'b0}, 1'b1, r, k);
        host.xfer(a, 1'b1, r, k);
        host.start_cond();
        host.xfer({`PLC_DEV_ADDR, 1'b1}, 1'b1, r, k);
        host.xfer(8'hff, 1'b1, d, k);
        host.stop_cond();
    endtask

    // Two bytes in one read: the host acknowledges the first
    task automatic reg_rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] r;
        logic       k;
        host.start_cond();
        host.xfer({`PLC_DEV_ADDR, 1'b0}, 1'b1, r, k);
        host.xfer(a, 1'b1, r, k);
        host.start_cond();
        host.xfer({`PLC_DEV_ADDR, 1'b1}, 1'b1, r, k);
        host.xfer(8'hff, 1'b0, d0, k);
        host.xfer(8'hff, 1'b1, d1, k);
        host.stop_cond();
    endtask

    // Status means nothing before completion, so wait for it first
    task automatic wait_done();
        int n;
        n = 0;
        while (int_oe !== 1'b1 && n < 300) begin
            @(negedge clock_i);
            n++;
        end
        if (int_oe !== 1'b1) begin
            mismatches++;
            finish_test();
        end
        check("not ready", {7'h0, dnr}, 8'h00);
    endtask

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial begin
        logic [7:0] d;
        logic [7:0] d2;
        mismatches  = 0;
        check_count = 0;
        rst_i       = 1'b1;
        sel_n       = 1'b0;
        rst_n       = 1'b1;
        lpm         = 1'b0;
        txdis       = 1'b0;
        rx_power    = 32'h80808080;
        repeat (16) @(negedge clock_i);
        rst_i = 1'b0;
        wait_done();
        check("presence oe", {7'h0, prs_oe}, 8'h01);
        check("presence level", {7'h0, prs_n}, 8'h00);
        check("int level", {7'h0, int_n}, 8'h00);
        reg_rd(`PLC_A_STATUS, d);
        check("status reg", d, 8'h00);
        reg_rd(`PLC_A_INT, d);
        check("int flags", d, 8'h01);
        $display("test power-up done");

        reg_rd(`PLC_A_THR, d);
        check("threshold", d, `PLC_THR_RST);
        reg_wr(`PLC_A_TXDIS, 8'h05, 1'b1);
        reg_rd(`PLC_A_TXDIS, d);
        check("txdis reg", d, 8'h05);
        check("tx off soft", {4'h0, tx_off}, 8'h05);
        txdis = 1'b1;
        settle();
        check("tx off both", {4'h0, tx_off}, 8'h0f);
        reg_wr(`PLC_A_TXDIS, 8'h00, 1'b1);
        check("tx off pin", {4'h0, tx_off}, 8'h0f);
        txdis = 1'b0;
        settle();
        check("tx on", {4'h0, tx_off}, 8'h00);
        $display("test transmit disable done");

        rx_power = 32'h80201f60;
        settle();
        check("loss one lane", {7'h0, loss}, 8'h01);
        for (int i = 0; i < `PLC_LANES; i++) begin
            reg_rd(`PLC_A_LANE0 + 8'(i), d);
            check("lane power", d, rx_power[8*i +: 8]);
        end
        reg_rd(`PLC_A_LOS, d);
        check("live loss", d, 8'h02);
        reg_rd2(`PLC_A_LANE0 + 8'h01, d, d2);
        check("lane burst first", d, rx_power[15:8]);
        check("lane burst second", d2, rx_power[23:16]);
        rx_power = 32'h80202060;
        settle();
        check("loss at threshold", {7'h0, loss}, 8'h00);
        reg_wr(`PLC_A_THR, 8'h21, 1'b1);
        settle();
        check("loss raised thr", {7'h0, loss}, 8'h01);
        reg_rd(`PLC_A_LOS, d);
        check("live loss thr", d, 8'h06);
        reg_rd(`PLC_A_INT, d);
        check("loss latched", d, 8'h61);
        $display("test signal loss done");

        lpm = 1'b1;
        settle();
        check("pin limit", {7'h0, pwr_lim}, 8'h01);
        reg_wr(`PLC_A_PWR, 8'h01, 1'b1);
        check("override off", {7'h0, pwr_lim}, 8'h00);
        reg_wr(`PLC_A_PWR, 8'h03, 1'b1);
        lpm = 1'b0;
        settle();
        check("override on", {7'h0, pwr_lim}, 8'h01);
        $display("test power limit done");

        reg_wr(`PLC_A_TXDIS, 8'h0f, 1'b1);
        sel_n = 1'b1;
        settle();
        reg_wr(`PLC_A_TXDIS, 8'h0a, 1'b0);
        sel_n = 1'b0;
        settle();
        reg_rd(`PLC_A_TXDIS, d);
        check("unselected write", d, 8'h0f);
        $display("test select done");

        // Loss latches would re-arm the interrupt while any lane is low
        rx_power = 32'h80808080;
        settle();
        reg_wr(`PLC_A_INT, 8'hff, 1'b1);
        settle();
        check("int released", {7'h0, int_oe}, 8'h00);
        reg_rd(`PLC_A_INT, d);
        check("int cleared", d, 8'h00);
        rst_n = 1'b0;
        repeat (100) @(negedge clock_i);
        rst_n = 1'b1;
        settle();
        check("short pulse", {7'h0, dnr}, 8'h00);
        rst_n = 1'b0;
        repeat (`PLC_RESET_MIN_CYC + 10) @(negedge clock_i);
        check("reset not ready", {7'h0, dnr}, 8'h01);
        check("reset int", {7'h0, int_oe}, 8'h00);
        rst_n = 1'b1;
        wait_done();
        check("tx off dflt", {4'h0, tx_off}, 8'h00);
        check("limit dflt", {7'h0, pwr_lim}, 8'h00);
        reg_rd(`PLC_A_THR, d);
        check("thr dflt", d, `PLC_THR_RST);
        reg_rd(`PLC_A_PWR, d);
        check("pwr dflt", d, {6'h0, `PLC_PWR_RST});
        reg_rd(`PLC_A_STATUS, d);
        check("status after reset", d, 8'h00);
        reg_rd(`PLC_A_INT, d);
        check("int after reset", d, 8'h01);
        $display("test module reset done");
        finish_test();
    end
endmodule
